// ==== maclf_pkg.sv ====
// constants, table layout and state encoding of the address lookup engine
package maclf_pkg;
  // geometry of the switch and of the address lookup table
  localparam int NPORTS = 7;
  localparam int PW = 3;
  localparam int MAC_W = 48;
  localparam int FID_W = 7;
  localparam int IDX_W = 10;
  localparam int BUCKETS = 1024;
  localparam int WAYS = 4;
  localparam int WAY_W = 2;
  localparam int TS_W = 12;
  localparam int MCAST_BIT = 40;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned SECOND_CYCLES = (SECOND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 26;
  localparam logic [10:0] AGE_DEFAULT_S = 11'd300;
  localparam logic [10:0] AGE_MIN_S = 11'd1;
  localparam logic [10:0] AGE_MAX_S = 11'd1800;

  // hash selection codes and hash constants
  localparam logic [1:0] HASH_CRC = 2'h1;
  localparam logic [1:0] HASH_XOR = 2'h2;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // register numbers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AGE = 8'h01;
  localparam logic [7:0] REG_INT_STS = 8'h02;
  localparam logic [7:0] REG_INT_MASK = 8'h03;
  localparam logic [7:0] REG_FAIL_IDX = 8'h04;
  localparam logic [7:0] REG_TBL_IDX = 8'h05;
  localparam logic [7:0] REG_TBL_MAC_LO = 8'h06;
  localparam logic [7:0] REG_TBL_MAC_HI = 8'h07;
  localparam logic [7:0] REG_TBL_CTRL = 8'h08;
  localparam logic [7:0] REG_EGRESS_BASE = 8'h10;

  // field positions
  localparam int CTRL_VLAN_BIT = 0;
  localparam int CTRL_AGE_BIT = 1;
  localparam int CTRL_HASH_LSB = 2;
  localparam int TBL_FID_LSB = 16;
  localparam int TBL_STATIC_BIT = 8;
  localparam int TBL_VALID_BIT = 9;
  localparam int TBL_WAY_LSB = 10;
  localparam int INT_FAIL_BIT = 0;

  // reset values
  localparam logic VLAN_EN_RESET = 1'b0;
  localparam logic AGE_EN_RESET = 1'b1;
  localparam logic [1:0] HASH_RESET = HASH_CRC;
  localparam logic FAIL_MASK_RESET = 1'b0;

  typedef struct packed {
    logic valid;
    logic stat;
    logic [MAC_W-1:0] mac;
    logic [FID_W-1:0] filter_group_id;
    logic [NPORTS-1:0] ports;
    logic [TS_W-1:0] ts;
  } maclf_entry_t;

  typedef maclf_entry_t [WAYS-1:0] maclf_bucket_t;

  typedef enum {
    S_INIT, S_IDLE, S_DA_RD, S_DA_CMP, S_SA_RD, S_SA_CMP, S_AGE_RD, S_AGE_CMP, S_SW_RD, S_SW_WR
  } maclf_state_t;
endpackage

// ==== maclf_hash.sv ====
// bucket index hash of address plus filter group
module maclf_hash (
  // key
  input wire logic [maclf_pkg::MAC_W-1:0] mac,
  input wire logic [maclf_pkg::FID_W-1:0] filter_group_id,
  input wire logic [1:0] sel,
  // index
  output logic [maclf_pkg::IDX_W-1:0] idx
);
  logic [15:0] fold;

  function automatic logic [15:0] crc16(input logic [maclf_pkg::MAC_W-1:0] data);
    logic [15:0] crc;
    logic fb;
    crc = maclf_pkg::CRC_INIT;
    for (int i = maclf_pkg::MAC_W - 1; i >= 0; i--) begin
      fb = crc[15] ^ data[i];
      crc = {crc[14:0], 1'b0};
      if (fb) begin
        crc = crc ^ maclf_pkg::CRC_POLY;
      end
    end
    return crc;
  endfunction

  always_comb begin
    unique case (sel)
      maclf_pkg::HASH_CRC: fold = crc16(mac);
      maclf_pkg::HASH_XOR: fold = mac[15:0] ^ mac[31:16] ^ mac[47:32];
      default: fold = mac[15:0];
    endcase
    // index wraps modulo the table size after adding the group
    idx = fold[maclf_pkg::IDX_W-1:0] + {3'h0, filter_group_id};
  end
endmodule

// ==== maclf_lookup.sv ====
// address lookup, learning, aging and forwarding mask engine
//
// Decided for this implementation: the placing of the registers and strobed register access.
module maclf_lookup #(
  parameter int unsigned TICK_CYCLES = maclf_pkg::SECOND_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // frame header from ingress port logic
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [47:0] req_da,
  input wire logic [47:0] req_sa,
  input wire logic [2:0] req_src_port,
  input wire logic [6:0] req_filter_group_id,
  input wire logic req_fid_member,
  input wire logic [3:0] req_err,
  input wire logic req_pause,
  input wire logic req_mgmt,
  input wire logic [6:0] req_vlan_mask,
  input wire logic [6:0] req_modify_mask,
  input wire logic [6:0] req_mirror_mask,
  input wire logic req_acl_valid,
  input wire logic [6:0] req_acl_mask,
  // result to queue manager
  output logic res_valid,
  output logic [6:0] final_port_mask,
  output logic res_drop,
  // flow control request
  output logic pause_valid,
  output logic [2:0] pause_port,
  // to global interrupt status
  output logic learn_fail_irq
);
  localparam int NP = maclf_pkg::NPORTS;
  localparam int IW = maclf_pkg::IDX_W;
  localparam int TW = maclf_pkg::TS_W;

  typedef struct packed {
    maclf_pkg::maclf_state_t state;
    logic [IW-1:0] idx;
    logic [IW-1:0] scan;
    logic [47:0] da;
    logic [47:0] sa;
    logic [6:0] filter_group_id;
    logic [2:0] src;
    logic frame_ok;
    logic fid_member;
    logic vlan_en;
    logic age_en;
    logic [1:0] hash_sel;
    logic [10:0] age_period;
    logic fail_sts;
    logic fail_mask;
    logic [IW-1:0] fail_idx;
    logic [11:0] tbl_idx;
    logic [47:0] tbl_mac;
    logic [6:0] tbl_fid;
    logic [6:0] tbl_ports;
    logic tbl_static;
    logic tbl_valid;
    logic sw_pend;
    logic [NP-1:0][NP-1:0] egress;
    logic [maclf_pkg::TICK_W-1:0] tick;
    logic [TW-1:0] now;
    logic [31:0] rdata;
    logic res_valid;
    logic res_drop;
    logic [NP-1:0] res_mask;
    logic pause_valid;
    logic [2:0] pause_port;
  } maclf_regs_t;

  localparam maclf_regs_t REGS_RESET = '{
    state: maclf_pkg::S_INIT,
    vlan_en: maclf_pkg::VLAN_EN_RESET,
    age_en: maclf_pkg::AGE_EN_RESET,
    hash_sel: maclf_pkg::HASH_RESET,
    age_period: maclf_pkg::AGE_DEFAULT_S,
    fail_mask: maclf_pkg::FAIL_MASK_RESET,
    egress: '1,
    default: '0
  };

  maclf_regs_t q, d;
  maclf_pkg::maclf_bucket_t mem [maclf_pkg::BUCKETS];
  maclf_pkg::maclf_bucket_t rd_bucket, wr_bucket;
  maclf_pkg::maclf_entry_t new_e;
  logic wr_en;
  logic [IW-1:0] mem_idx, hidx;
  logic [47:0] hmac;
  logic [6:0] hfid, st_ports, dy_ports, stage1, modified, fwd;
  logic st_hit, dy_hit, hit, local_hit, drop;
  logic sa_hit, free_found, old_found, learn_ok, fail_set, fail_clr, aged;
  logic [maclf_pkg::WAY_W-1:0] sa_way, free_way, old_way, sw_way;
  logic [TW-1:0] old_age;
  logic [10:0] age_wr;

  function automatic logic [NP-1:0] onehot(input logic [2:0] p);
    return NP'(7'h01 << p);
  endfunction

  function automatic logic key_match(input maclf_pkg::maclf_entry_t e, input logic [47:0] mac,
                                     input logic [6:0] filter_group_id);
    return e.valid && (e.mac == mac) && (e.filter_group_id == filter_group_id);
  endfunction

  function automatic logic [TW-1:0] age_of(input logic [TW-1:0] now, input logic [TW-1:0] ts);
    return TW'(now - ts);
  endfunction

  // one hash unit, shared between destination and source lookups
  assign hmac = (q.state == maclf_pkg::S_IDLE) ? req_da : q.sa;
  assign hfid = (q.state == maclf_pkg::S_IDLE) ? (q.vlan_en ? req_filter_group_id : 7'h00) : q.filter_group_id;

  maclf_hash u_hash (
    .mac(hmac),
    .filter_group_id(hfid),
    .sel(q.hash_sel),
    .idx(hidx)
  );

  assign mem_idx = (q.state == maclf_pkg::S_INIT) ? q.scan : q.idx;

  // one bucket per word so all four ways compare in one cycle
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[mem_idx] <= wr_bucket;
    end
    rd_bucket <= mem[mem_idx];
  end

  always_comb begin
    d = q;
    d.res_valid = 1'b0;
    d.pause_valid = 1'b0;
    wr_en = 1'b0;
    wr_bucket = rd_bucket;
    st_hit = 1'b0;
    dy_hit = 1'b0;
    st_ports = '0;
    dy_ports = '0;
    sa_hit = 1'b0;
    sa_way = '0;
    free_found = 1'b0;
    free_way = '0;
    old_found = 1'b0;
    old_way = '0;
    old_age = '0;
    fail_set = 1'b0;
    aged = 1'b0;
    sw_way = q.tbl_idx[maclf_pkg::TBL_WAY_LSB +: maclf_pkg::WAY_W];
    new_e = '{valid: 1'b1, stat: 1'b0, mac: q.sa, filter_group_id: q.filter_group_id, ports: onehot(q.src), ts: q.now};

    // seconds base for time stamps
    if (q.tick == maclf_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      d.tick = '0;
      d.now = TW'(q.now + 1'b1);
    end else begin
      d.tick = maclf_pkg::TICK_W'(q.tick + 1'b1);
    end

    // destination lookup: all ways at once, static beats dynamic
    for (int w = 0; w < maclf_pkg::WAYS; w++) begin
      if (key_match(rd_bucket[w], q.da, q.filter_group_id)) begin
        if (rd_bucket[w].stat) begin
          st_hit = 1'b1;
          st_ports = rd_bucket[w].ports;
        end else begin
          dy_hit = 1'b1;
          dy_ports = rd_bucket[w].ports;
        end
      end
    end
    hit = st_hit | dy_hit;
    stage1 = st_hit ? st_ports : (dy_hit ? dy_ports : q.res_mask);
    local_hit = hit && (stage1 == onehot(q.src));

    // source lookup and victim choice
    for (int w = 0; w < maclf_pkg::WAYS; w++) begin
      if (key_match(rd_bucket[w], q.sa, q.filter_group_id)) begin
        sa_hit = 1'b1;
        sa_way = maclf_pkg::WAY_W'(w);
      end
      if (!rd_bucket[w].valid) begin
        if (!free_found) begin
          free_found = 1'b1;
          free_way = maclf_pkg::WAY_W'(w);
        end
      end else if (!rd_bucket[w].stat && (!old_found || age_of(q.now, rd_bucket[w].ts) >= old_age)) begin
        old_found = 1'b1;
        old_way = maclf_pkg::WAY_W'(w);
        old_age = age_of(q.now, rd_bucket[w].ts);
      end
    end
    // unicast means the group bit of the first octet is clear
    learn_ok = q.frame_ok && !q.sa[maclf_pkg::MCAST_BIT] && (!q.vlan_en || q.fid_member);

    unique case (q.state)
      maclf_pkg::S_INIT: begin
        wr_en = 1'b1;
        wr_bucket = '0;
        d.scan = IW'(q.scan + 1'b1);
        if (q.scan == IW'(maclf_pkg::BUCKETS - 1)) begin
          d.state = maclf_pkg::S_IDLE;
        end
      end
      maclf_pkg::S_IDLE: begin
        if (q.sw_pend) begin
          d.idx = q.tbl_idx[IW-1:0];
          d.state = maclf_pkg::S_SW_RD;
        end else if (req_valid) begin
          d.da = req_da;
          d.sa = req_sa;
          d.src = req_src_port;
          d.filter_group_id = q.vlan_en ? req_filter_group_id : 7'h00;
          d.fid_member = req_fid_member;
          d.frame_ok = (req_err == 4'h0);
          d.idx = hidx;
          // the VLAN mask is parked in the result register until compare
          d.res_mask = req_vlan_mask;
          d.res_drop = (req_err != 4'h0) | req_mgmt | req_pause;
          d.pause_valid = req_pause;
          d.pause_port = req_src_port;
          d.state = maclf_pkg::S_DA_RD;
        end else if (q.age_en) begin
          d.idx = q.scan;
          d.state = maclf_pkg::S_AGE_RD;
        end
      end
      maclf_pkg::S_DA_RD: begin
        d.state = maclf_pkg::S_DA_CMP;
      end
      maclf_pkg::S_DA_CMP: begin
        d.idx = hidx;
        d.res_valid = 1'b1;
        d.res_drop = q.res_drop | local_hit;
        d.res_mask = fwd;
        d.state = maclf_pkg::S_SA_RD;
      end
      maclf_pkg::S_SA_RD: begin
        d.state = maclf_pkg::S_SA_CMP;
      end
      maclf_pkg::S_SA_CMP: begin
        d.state = maclf_pkg::S_IDLE;
        if (sa_hit) begin
          // static records keep their port and stamp
          if (!rd_bucket[sa_way].stat) begin
            wr_en = 1'b1;
            wr_bucket[sa_way].ts = q.now;
            if (q.frame_ok) begin
              wr_bucket[sa_way].ports = onehot(q.src);
            end
          end
        end else if (learn_ok) begin
          if (free_found) begin
            wr_en = 1'b1;
            wr_bucket[free_way] = new_e;
          end else if (old_found) begin
            wr_en = 1'b1;
            wr_bucket[old_way] = new_e;
          end else begin
            fail_set = 1'b1;
            d.fail_idx = q.idx;
          end
        end
      end
      maclf_pkg::S_AGE_RD: begin
        d.state = maclf_pkg::S_AGE_CMP;
      end
      maclf_pkg::S_AGE_CMP: begin
        for (int w = 0; w < maclf_pkg::WAYS; w++) begin
          if (rd_bucket[w].valid && !rd_bucket[w].stat &&
              age_of(q.now, rd_bucket[w].ts) > TW'(q.age_period)) begin
            wr_bucket[w].valid = 1'b0;
            aged = 1'b1;
          end
        end
        wr_en = aged && q.age_en;
        d.scan = IW'(q.scan + 1'b1);
        d.state = maclf_pkg::S_IDLE;
      end
      maclf_pkg::S_SW_RD: begin
        d.state = maclf_pkg::S_SW_WR;
      end
      maclf_pkg::S_SW_WR: begin
        wr_en = 1'b1;
        wr_bucket[sw_way] = '{valid: q.tbl_valid, stat: q.tbl_static, mac: q.tbl_mac, filter_group_id: q.tbl_fid,
                              ports: q.tbl_ports, ts: q.now};
        d.sw_pend = 1'b0;
        d.state = maclf_pkg::S_IDLE;
      end
    endcase

    // register writes
    fail_clr = reg_we && (reg_addr == maclf_pkg::REG_INT_STS) && reg_wdata[maclf_pkg::INT_FAIL_BIT];
    d.fail_sts = (q.fail_sts & ~fail_clr) | fail_set;
    age_wr = reg_wdata[10:0];
    if (reg_we) begin
      unique case (reg_addr)
        maclf_pkg::REG_CTRL: begin
          d.vlan_en = reg_wdata[maclf_pkg::CTRL_VLAN_BIT];
          d.age_en = reg_wdata[maclf_pkg::CTRL_AGE_BIT];
          d.hash_sel = reg_wdata[maclf_pkg::CTRL_HASH_LSB +: 2];
        end
        maclf_pkg::REG_AGE: begin
          // out-of-range periods in bits 10:0 clamp rather than wrap; higher bits are dropped first
          if (age_wr < maclf_pkg::AGE_MIN_S) begin
            d.age_period = maclf_pkg::AGE_MIN_S;
          end else if (age_wr > maclf_pkg::AGE_MAX_S) begin
            d.age_period = maclf_pkg::AGE_MAX_S;
          end else begin
            d.age_period = age_wr;
          end
        end
        maclf_pkg::REG_INT_MASK: d.fail_mask = reg_wdata[maclf_pkg::INT_FAIL_BIT];
        maclf_pkg::REG_TBL_IDX: d.tbl_idx = reg_wdata[11:0];
        maclf_pkg::REG_TBL_MAC_LO: d.tbl_mac[31:0] = reg_wdata;
        maclf_pkg::REG_TBL_MAC_HI: begin
          d.tbl_mac[47:32] = reg_wdata[15:0];
          d.tbl_fid = reg_wdata[maclf_pkg::TBL_FID_LSB +: 7];
        end
        maclf_pkg::REG_TBL_CTRL: begin
          d.tbl_ports = reg_wdata[6:0];
          d.tbl_static = reg_wdata[maclf_pkg::TBL_STATIC_BIT];
          d.tbl_valid = reg_wdata[maclf_pkg::TBL_VALID_BIT];
          d.sw_pend = 1'b1;
        end
        default: begin
          if (reg_addr >= maclf_pkg::REG_EGRESS_BASE && reg_addr < maclf_pkg::REG_EGRESS_BASE + 8'(NP)) begin
            d.egress[3'(reg_addr - maclf_pkg::REG_EGRESS_BASE)] = reg_wdata[6:0];
          end
        end
      endcase
    end

    // register reads
    if (reg_re) begin
      d.rdata = '0;
      unique case (reg_addr)
        maclf_pkg::REG_CTRL: d.rdata[3:0] = {q.hash_sel, q.age_en, q.vlan_en};
        maclf_pkg::REG_AGE: d.rdata[10:0] = q.age_period;
        maclf_pkg::REG_INT_STS: d.rdata[maclf_pkg::INT_FAIL_BIT] = q.fail_sts;
        maclf_pkg::REG_INT_MASK: d.rdata[maclf_pkg::INT_FAIL_BIT] = q.fail_mask;
        maclf_pkg::REG_FAIL_IDX: d.rdata[IW-1:0] = q.fail_idx;
        maclf_pkg::REG_TBL_IDX: d.rdata[11:0] = q.tbl_idx;
        maclf_pkg::REG_TBL_MAC_LO: d.rdata = q.tbl_mac[31:0];
        maclf_pkg::REG_TBL_MAC_HI: d.rdata[22:0] = {q.tbl_fid, q.tbl_mac[47:32]};
        maclf_pkg::REG_TBL_CTRL: d.rdata[9:0] = {q.tbl_valid, q.tbl_static, 1'b0, q.tbl_ports};
        default: begin
          if (reg_addr >= maclf_pkg::REG_EGRESS_BASE && reg_addr < maclf_pkg::REG_EGRESS_BASE + 8'(NP)) begin
            d.rdata[NP-1:0] = q.egress[3'(reg_addr - maclf_pkg::REG_EGRESS_BASE)];
          end
        end
      endcase
    end
  end

  // forwarding stages; the side masks are taken live during the compare cycle
  always_comb begin
    modified = '0;
    drop = q.res_drop | local_hit;
    modified = (stage1 & req_modify_mask) | req_mirror_mask;
    fwd = req_acl_valid ? req_acl_mask : modified;
    // egress restriction last so nothing can bypass it, VLAN mode or not
    fwd = fwd & q.egress[q.src];
    if (drop) begin
      fwd = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= reset ? REGS_RESET : d;
  end

  assign req_ready = (q.state == maclf_pkg::S_IDLE) && !q.sw_pend;
  assign reg_rdata = q.rdata;
  assign res_valid = q.res_valid;
  assign final_port_mask = q.res_mask;
  assign res_drop = q.res_drop;
  assign pause_valid = q.pause_valid;
  assign pause_port = q.pause_port;
  assign learn_fail_irq = q.fail_sts & ~q.fail_mask;
endmodule

// ==== maclf_ingress_model.sv ====
// stand-in for ingress port logic and queue manager around the lookup engine
module maclf_ingress_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bench control
  input wire logic send,
  output logic done,
  output logic [6:0] got_mask,
  output logic got_drop,
  // engine side
  input wire logic req_ready,
  input wire logic res_valid,
  input wire logic [6:0] final_port_mask,
  input wire logic res_drop,
  output logic req_valid
);
  // offer stays up until taken; the bench holds every qualifier until done
  always_ff @(posedge clk) begin
    done <= res_valid;
    if (reset) begin
      req_valid <= 1'b0;
    end else if (send) begin
      req_valid <= 1'b1;
    end else if (req_ready) begin
      req_valid <= 1'b0;
    end
    if (res_valid) begin
      got_mask <= final_port_mask;
      got_drop <= res_drop;
    end
  end
endmodule

// ==== maclf_lookup_chk.sv ====
// port assertions of the address lookup engine
module maclf_lookup_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  // frame side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [2:0] req_src_port,
  input wire logic [3:0] req_err,
  input wire logic req_pause,
  input wire logic req_mgmt,
  input wire logic res_valid,
  input wire logic [6:0] final_port_mask,
  input wire logic res_drop,
  input wire logic pause_valid,
  input wire logic [2:0] pause_port,
  input wire logic learn_fail_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic acc;
  assign acc = req_valid && req_ready;
  res_delay_a: assert property (acc |-> ##3 res_valid)
    else $error("no result three cycles after accept");
  res_pulse_a: assert property (res_valid |=> !res_valid)
    else $error("result longer than one cycle");
  busy_gap_a: assert property (res_valid |-> !req_ready [*2])
    else $error("ready too soon after result");
  err_drop_a: assert property (acc && req_err != 4'h0 |-> ##3 res_drop && final_port_mask == 7'h00)
    else $error("error frame forwarded");
  mgmt_drop_a: assert property (acc && req_mgmt |-> ##3 res_drop && final_port_mask == 7'h00)
    else $error("management frame forwarded");
  pause_flow_a: assert property (acc && req_pause |=> pause_valid && pause_port == $past(req_src_port) ##2 res_drop)
    else $error("pause frame not consumed");
  pause_cause_a: assert property (pause_valid |-> $past(acc && req_pause))
    else $error("flow control without pause frame");
  irq_cause_a: assert property ($rose(learn_fail_irq) |-> $past(res_valid, 2) || $past(reg_we) || $past(reg_we, 2))
    else $error("learn failure interrupt without cause");
  rdata_hold_a: assert property (!$past(reg_re) && !$past(reset) |-> $stable(reg_rdata))
    else $error("read data changed without read");
  cover property (acc && req_pause);
  cover property (acc && req_err != 4'h0);
  cover property ($rose(learn_fail_irq));
endmodule

// ==== maclf_lookup_tb_top.sv ====
// self-checking bench of the address lookup engine
module maclf_lookup_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] MA = 48'h0000_1111_2202, MB = 48'h0000_3333_4404, MZ = 48'h0000_7777_0808;
  localparam logic [47:0] MU = 48'h0000_9999_0A0A, MM = 48'h0100_5E00_0033;
  // both map to bucket 0x155 under the direct hash
  localparam logic [47:0] MS = 48'h0002_0000_0155, MN = 48'h0004_0000_0155;
  localparam logic [6:0] FL = 7'h61;
  logic clk = 1'b0, reset = 1'b1, reg_we = 1'b0, reg_re = 1'b0, send = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [47:0] req_da = 48'h0, req_sa = 48'h0;
  logic [2:0] req_src_port = 3'h0, pause_port;
  logic [3:0] req_err = 4'h0;
  logic req_fid_member = 1'b1, req_pause = 1'b0, req_mgmt = 1'b0, req_acl_valid = 1'b0;
  logic [6:0] req_filter_group_id = 7'h00, req_vlan_mask = FL, req_modify_mask = 7'h7F;
  logic [6:0] req_mirror_mask = 7'h00, req_acl_mask = 7'h00, final_port_mask, got_mask;
  logic req_valid, req_ready, res_valid, res_drop, pause_valid, learn_fail_irq, done, got_drop;
  int err_count = 0;
  int samples_checked = 0;
  maclf_lookup #(.TICK_CYCLES(40)) dut_u (.clk, .reset, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .req_valid, .req_ready, .req_da, .req_sa, .req_src_port, .req_filter_group_id, .req_fid_member, .req_err,
    .req_pause, .req_mgmt, .req_vlan_mask, .req_modify_mask, .req_mirror_mask, .req_acl_valid, .req_acl_mask,
    .res_valid, .final_port_mask, .res_drop, .pause_valid, .pause_port, .learn_fail_irq);
  maclf_ingress_model model_u (.clk, .reset, .send, .done, .got_mask, .got_drop, .req_ready, .res_valid,
    .final_port_mask, .res_drop, .req_valid);
  always #12.5 clk = ~clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  // one frame; an empty mask means the frame must be dropped
  task automatic fwd(input logic [47:0] da, input logic [47:0] sa, input logic [2:0] sp, input logic [6:0] m);
    int n;
    n = 0;
    @(posedge clk);
    req_da <= da;
    req_sa <= sa;
    req_src_port <= sp;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 300);
    chk(32'(n < 300), 32'h1);
    chk(32'(got_mask), 32'(m));
    chk(32'(got_drop), 32'(m == 7'h00));
    // learn write lands two cycles after the result
    repeat (4) @(posedge clk);
  endtask
  task automatic t_regs();
    rd(maclf_pkg::REG_CTRL, 32'h6);
    rd(maclf_pkg::REG_AGE, 32'h12C);
    for (int p = 0; p < 7; p++) begin
      rd(maclf_pkg::REG_EGRESS_BASE + 8'(p), 32'h7F);
    end
    wr(maclf_pkg::REG_AGE, 32'h0);
    rd(maclf_pkg::REG_AGE, 32'h1);
    wr(maclf_pkg::REG_AGE, 32'h7D0);
    rd(maclf_pkg::REG_AGE, 32'h708);
    wr(8'h3F, 32'hFFFF_FFFF);
    rd(8'h3F, 32'h0);
    wr(maclf_pkg::REG_FAIL_IDX, 32'h3FF);
    rd(maclf_pkg::REG_FAIL_IDX, 32'h0);
    $display("registers done");
  endtask
  task automatic t_learn();
    fwd(MU, MA, 3'h2, FL);
    fwd(MA, MZ, 3'h5, 7'h04);
    fwd(MU, MA, 3'h3, FL);
    fwd(MA, MZ, 3'h5, 7'h08);
    fwd(MA, MA, 3'h3, 7'h00);
    for (int e = 0; e < 4; e++) begin
      req_err <= 4'(1 << e);
      fwd(MU, MB, 3'h2, 7'h00);
    end
    req_err <= 4'h0;
    fwd(MB, MZ, 3'h5, FL);
    fwd(MU, MM, 3'h2, FL);
    fwd(MM, MZ, 3'h5, FL);
    $display("learning done");
  endtask
  task automatic t_filter();
    req_pause <= 1'b1;
    fwd(MU, MM, 3'h2, 7'h00);
    req_pause <= 1'b0;
    req_mgmt <= 1'b1;
    fwd(MU, MM, 3'h2, 7'h00);
    req_mgmt <= 1'b0;
    wr(maclf_pkg::REG_CTRL, 32'h7);
    req_fid_member <= 1'b0;
    fwd(MU, MB, 3'h2, FL);
    req_fid_member <= 1'b1;
    fwd(MB, MZ, 3'h5, FL);
    wr(maclf_pkg::REG_EGRESS_BASE + 8'h5, 32'h7E);
    fwd(MU, MZ, 3'h5, 7'h60);
    // xor fold hash from here on
    wr(maclf_pkg::REG_CTRL, 32'hA);
    fwd(MU, MZ, 3'h5, 7'h60);
    wr(maclf_pkg::REG_EGRESS_BASE + 8'h5, 32'h7F);
    req_acl_valid <= 1'b1;
    req_acl_mask <= 7'h12;
    fwd(MA, MZ, 3'h5, 7'h12);
    req_acl_valid <= 1'b0;
    fwd(MZ, MA, 3'h3, 7'h20);
    $display("filtering done");
  endtask
  task automatic t_static();
    wr(maclf_pkg::REG_CTRL, 32'h2);
    for (int k = 0; k < 4; k++) begin
      wr(maclf_pkg::REG_TBL_IDX, 32'((k << 10) | 'h155));
      wr(maclf_pkg::REG_TBL_MAC_LO, 32'((k << 16) | 'h155));
      wr(maclf_pkg::REG_TBL_MAC_HI, 32'h2);
      wr(maclf_pkg::REG_TBL_CTRL, 32'h340);
      // staging is read until the commit lands, up to five cycles behind an aging slot
      repeat (4) @(posedge clk);
    end
    fwd(MS, MZ, 3'h5, 7'h40);
    fwd(MU, MN, 3'h2, FL);
    chk(32'(learn_fail_irq), 32'h1);
    rd(maclf_pkg::REG_FAIL_IDX, 32'h155);
    rd(maclf_pkg::REG_INT_STS, 32'h1);
    fwd(MS, MZ, 3'h5, 7'h40);
    fwd(MN, MZ, 3'h5, FL);
    wr(maclf_pkg::REG_INT_STS, 32'h1);
    rd(maclf_pkg::REG_INT_STS, 32'h0);
    wr(maclf_pkg::REG_INT_MASK, 32'h1);
    fwd(MU, MN, 3'h2, FL);
    chk(32'(learn_fail_irq), 32'h0);
    $display("static done");
  endtask
  task automatic t_age();
    wr(maclf_pkg::REG_CTRL, 32'h0);
    wr(maclf_pkg::REG_AGE, 32'h2);
    fwd(MU, MB, 3'h4, FL);
    repeat (4000) @(posedge clk);
    fwd(MB, MZ, 3'h5, 7'h10);
    wr(maclf_pkg::REG_CTRL, 32'h2);
    // a refresh about every 72 cycles keeps the stamp under two seconds old
    for (int i = 0; i < 120; i++) begin
      fwd(MU, MA, 3'h3, FL);
      repeat (60) @(posedge clk);
    end
    fwd(MA, MZ, 3'h5, 7'h08);
    fwd(MB, MZ, 3'h5, FL);
    fwd(MS, MZ, 3'h5, 7'h40);
    $display("aging done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    // table clear sweep after reset
    repeat (1030) @(posedge clk);
    t_learn();
    t_filter();
    t_static();
    t_age();
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule
bind maclf_lookup maclf_lookup_chk chk_u (.clk, .reset, .reg_we, .reg_re, .reg_rdata, .req_valid, .req_ready,
  .req_src_port, .req_err, .req_pause, .req_mgmt, .res_valid, .final_port_mask, .res_drop, .pause_valid,
  .pause_port, .learn_fail_irq);
